/* core/scg_top.sv */
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
`include "scg_cfg.svh"
module scg_top #(
  parameter int FAULT_CYCLES = `SCG_FAULT_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rdata,
  input  wire logic       internal_osc_clock,
  input  wire logic       low_freq_crystal_clock,
  input  wire logic       second_crystal_clock,
  output logic            main_clock,
  output logic            subsystem_clock,
  output logic            aux_clock,
  output logic            main_clock_pin,
  output logic            subsystem_clock_pin,
  output logic            aux_clock_pin,
  output logic            first_osc_enable,
  output logic            second_osc_enable,
  output logic            first_osc_hf_mode,
  output logic            osc_resistor_select,
  output logic      [7:0] dco_freq_code,
  output logic            osc_fault_flag,
  output logic            nmi_req,
  output logic            irq
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] ctrl_reg;
  logic [7:0] dco_reg;
  logic [2:0] pins_reg;
  logic [1:0] stat_reg;
  logic [1:0] stat_next;
  logic [1:0] ien_reg;
  logic [7:0] rdata_reg;
  logic [1:0] osc_en_reg;
  logic       aux_reg;
  logic       main_pin_reg;
  logic       sub_pin_reg;
  logic       aux_pin_reg;
  logic       nmi_reg;
  logic       irq_reg;

  logic [1:0]        osc_in;
  logic [1:0]        osc_dead;
  logic [1:0]        osc_en_next;
  logic [1:0]        clr_bits;
  logic [1:0]        events;
  logic              fault_any;
  logic              failsafe_hit;
  logic              wr_ctrl;
  scg_pkg::scg_src_t msel;
  scg_pkg::scg_src_t main_target;
  scg_pkg::scg_src_t sub_target;

  scg_clk_if main_if ();
  scg_clk_if sub_if ();

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  assign wr_ctrl = wr_en && (addr == `SCG_OFS_CTRL);

  always_ff @(posedge clk)
  begin
    if (rst)
      ctrl_reg <= `SCG_CTRL_RST; // R2 R8
    else if (wr_ctrl)
      ctrl_reg <= wdata;
  end

  // Frequency code returns to nominal on reset
  always_ff @(posedge clk)
  begin
    if (rst)
      dco_reg <= `SCG_DCO_RST; // R2
    else if (wr_en && (addr == `SCG_OFS_DCO))
      dco_reg <= wdata;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      pins_reg <= `SCG_PINS_RST;
    else if (wr_en && (addr == `SCG_OFS_PINS))
      pins_reg <= wdata[2:0];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      ien_reg <= 2'h0;
    else if (wr_en && (addr == `SCG_OFS_IEN))
      ien_reg <= wdata[1:0];
  end

  // ----------------------------------------
  // Source selection
  // ----------------------------------------
  // Code 3 is not a source; it falls back to the internal oscillator
  always_comb
  begin
    case (ctrl_reg[`SCG_CTRL_MSEL_LSB +: 2])
      2'h1:    msel = scg_pkg::SRC_LF;
      2'h2:    msel = scg_pkg::SRC_XT2;
      default: msel = scg_pkg::SRC_DCO;
    endcase
  end

  // While the fault flag stands the main clock stays on the internal one
  assign main_target = stat_reg[`SCG_ST_FAULT] ? scg_pkg::SRC_DCO : msel; // R3
  assign sub_target  = ctrl_reg[`SCG_CTRL_SSEL] ? scg_pkg::SRC_XT2 : scg_pkg::SRC_DCO; // R4

  // ----------------------------------------
  // Oscillator enables
  // ----------------------------------------
  assign osc_en_next[0] = !ctrl_reg[`SCG_CTRL_OSC1_OFF] // R7
                          || (main_if.cur == scg_pkg::SRC_LF)
                          || (main_target == scg_pkg::SRC_LF);
  assign osc_en_next[1] = !ctrl_reg[`SCG_CTRL_OSC2_OFF] // R9
                          || (main_if.cur == scg_pkg::SRC_XT2)
                          || (main_target == scg_pkg::SRC_XT2);

  // First crystal on and second off straight out of reset
  always_ff @(posedge clk)
  begin
    if (rst)
      osc_en_reg <= `SCG_OSC_EN_RST; // R7 R8
    else
      osc_en_reg <= osc_en_next;
  end

  // ----------------------------------------
  // Fault monitors
  // ----------------------------------------
  assign osc_in = {second_crystal_clock, low_freq_crystal_clock};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_mon
      logic        prev_reg;
      logic [15:0] cnt_reg;
      logic        dead_reg;
      // A stopped oscillator is not watched, so disabling it raises no fault
      always_ff @(posedge clk)
      begin
        if (rst || !osc_en_reg[gi])
        begin
          prev_reg <= 1'b0;
          cnt_reg  <= 16'h0;
          dead_reg <= 1'b0;
        end
        else
        begin
          prev_reg <= osc_in[gi];
          if (osc_in[gi] != prev_reg)
          begin
            cnt_reg  <= 16'h0;
            dead_reg <= 1'b0;
          end
          else if (cnt_reg >= 16'(FAULT_CYCLES - 1))
            dead_reg <= 1'b1;
          else
            cnt_reg <= cnt_reg + 16'h1;
        end
      end
      assign osc_dead[gi] = dead_reg;
    end
  endgenerate

  assign fault_any    = |osc_dead;
  assign failsafe_hit = (osc_dead[0] && (main_if.cur == scg_pkg::SRC_LF))
                        || (osc_dead[1] && (main_if.cur == scg_pkg::SRC_XT2));

  // ----------------------------------------
  // Status and interrupt
  // ----------------------------------------
  assign clr_bits  = (wr_en && (addr == `SCG_OFS_CLR)) ? wdata[1:0] : 2'h0;
  assign events    = {failsafe_hit, fault_any};
  // Set beats clear in the same cycle
  assign stat_next = (stat_reg & ~clr_bits) | events; // R11

  always_ff @(posedge clk)
  begin
    if (rst)
      stat_reg <= 2'h0;
    else
      stat_reg <= stat_next; // R11
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      nmi_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else
    begin
      nmi_reg <= stat_reg[`SCG_ST_FAULT]; // R11
      irq_reg <= |(stat_reg & ien_reg);
    end
  end

  // ----------------------------------------
  // Clock muxes
  // ----------------------------------------
  assign main_if.src    = {second_crystal_clock, low_freq_crystal_clock, internal_osc_clock};
  assign main_if.dead   = {osc_dead, 1'b0};
  assign main_if.target = main_target;
  assign sub_if.src     = {second_crystal_clock, low_freq_crystal_clock, internal_osc_clock};
  assign sub_if.dead    = {osc_dead, 1'b0};
  assign sub_if.target  = sub_target;

  scg_clk_mux u_main_mux ( // R1 R12
    .clk (clk),
    .rst (rst),
    .m   (main_if.mux)
  );

  scg_clk_mux u_sub_mux ( // R1 R4
    .clk (clk),
    .rst (rst),
    .m   (sub_if.mux)
  );

  // Auxiliary clock has no mux; it follows the first crystal only
  always_ff @(posedge clk)
  begin
    if (rst)
      aux_reg <= 1'b0;
    else
      aux_reg <= low_freq_crystal_clock; // R1 R5
  end

  // ----------------------------------------
  // Pin outputs
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      aux_pin_reg  <= 1'b0;
      main_pin_reg <= 1'b0;
      sub_pin_reg  <= 1'b0;
    end
    else
    begin
      aux_pin_reg  <= pins_reg[0] && aux_reg; // R10
      main_pin_reg <= pins_reg[1] && main_if.clk_out; // R10
      sub_pin_reg  <= pins_reg[2] && sub_if.clk_out; // R10
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_reg <= 8'h0;
    else if (!rd_en)
      rdata_reg <= 8'h0;
    else if (addr == `SCG_OFS_CTRL)
      rdata_reg <= ctrl_reg;
    else if (addr == `SCG_OFS_DCO)
      rdata_reg <= dco_reg;
    else if (addr == `SCG_OFS_PINS)
      rdata_reg <= {5'h0, pins_reg};
    else if (addr == `SCG_OFS_STAT)
      rdata_reg <= {6'h0, stat_reg};
    else if (addr == `SCG_OFS_IEN)
      rdata_reg <= {6'h0, ien_reg};
    else if (addr == `SCG_OFS_STATE)
      rdata_reg <= {1'b0, main_if.busy, osc_dead, osc_en_reg, main_if.cur};
    else
      rdata_reg <= 8'h0;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata               = rdata_reg;
  assign main_clock          = main_if.clk_out;
  assign subsystem_clock     = sub_if.clk_out;
  assign aux_clock           = aux_reg;
  assign main_clock_pin      = main_pin_reg;
  assign subsystem_clock_pin = sub_pin_reg;
  assign aux_clock_pin       = aux_pin_reg;
  assign first_osc_enable    = osc_en_reg[0];
  assign second_osc_enable   = osc_en_reg[1];
  assign first_osc_hf_mode   = ctrl_reg[`SCG_CTRL_HFMODE]; // R6
  assign osc_resistor_select = ctrl_reg[`SCG_CTRL_RSEL];
  assign dco_freq_code       = dco_reg;
  assign osc_fault_flag      = stat_reg[`SCG_ST_FAULT];
  assign nmi_req             = nmi_reg;
  assign irq                 = irq_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_out_of_reset;
    $past(rst) ##0 !rst;
  endsequence

  a_reset_defaults: assert property ( // R2 R8
    s_out_of_reset |-> (main_if.cur == scg_pkg::SRC_DCO) && !osc_resistor_select
                       && !second_osc_enable && first_osc_enable
                       && (dco_freq_code == `SCG_DCO_RST))
    else $error("wrong state after reset");

  a_fault_fallback: assert property ( // R3
    osc_fault_flag && main_if.dead[main_if.cur]
    |=> main_if.busy || (main_if.cur != $past(main_if.cur)))
    else $error("main clock not moved off a dead crystal");

  a_sub_source: assert property ( // R4
    (sub_if.target != scg_pkg::SRC_LF) && (sub_if.cur != scg_pkg::SRC_LF)
    && (ctrl_reg[`SCG_CTRL_SSEL] == (sub_if.target == scg_pkg::SRC_XT2)))
    else $error("subsystem clock source not as selected");

  a_aux_follows: assert property ( // R5
    !$past(rst) |-> (aux_clock == $past(low_freq_crystal_clock)))
    else $error("auxiliary clock does not follow first crystal");

  a_first_osc_runs: assert property ( // R7
    ($past(!ctrl_reg[`SCG_CTRL_OSC1_OFF]) || $past(main_if.cur == scg_pkg::SRC_LF))
    && !$past(rst) |-> first_osc_enable)
    else $error("first crystal stopped while needed");

  a_second_osc_main: assert property ( // R9
    ($past(main_if.cur == scg_pkg::SRC_XT2) && !$past(rst)) |-> second_osc_enable)
    else $error("second crystal stopped while sourcing main clock");

  a_second_osc_off: assert property ( // R9
    ($past(ctrl_reg[`SCG_CTRL_OSC2_OFF]) && $past(main_if.cur != scg_pkg::SRC_XT2)
     && $past(main_if.target != scg_pkg::SRC_XT2) && !$past(rst)) |-> !second_osc_enable)
    else $error("second crystal runs while disabled and unused");

  a_pin_main: assert property ( // R10
    !$past(rst) |-> (main_clock_pin == ($past(pins_reg[1]) && $past(main_clock))))
    else $error("main clock pin wrong");

  a_flag_sticky: assert property ( // R11
    (osc_fault_flag && !(wr_en && (addr == `SCG_OFS_CLR) && wdata[0])) |=> osc_fault_flag)
    else $error("fault flag dropped without a clear");

  a_flag_sets: assert property ( // R11
    fault_any |=> osc_fault_flag ##1 nmi_req)
    else $error("fault did not raise flag and NMI");
endmodule

/* pkg/scg_cfg.svh */
`ifndef SCG_CFG_SVH
`define SCG_CFG_SVH
// How it works
// R1: Three clocks: main, subsystem, auxiliary.
// R2: Reset picks internal oscillator, resistor select cleared.
// R3: Failing crystal on main clock falls back.
// R4: Subsystem clock picks second crystal or internal.
// R5: Auxiliary clock comes only from first crystal.
// R6: First crystal has watch and high-frequency modes.
// R7: First crystal runs; disable stops it unless main.
// R8: Second crystal starts disabled after reset.
// R9: Second crystal disable stops it unless main.
// R10: All three clocks can drive port pins.
// R11: Sticky fault flag raises the shared NMI.
// R12: Main clock switches without shortened phases.

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SCG_OFS_CTRL  4'h0
`define SCG_OFS_DCO   4'h1
`define SCG_OFS_PINS  4'h2
`define SCG_OFS_STAT  4'h3
`define SCG_OFS_CLR   4'h4
`define SCG_OFS_IEN   4'h5
`define SCG_OFS_STATE 4'h6

// ----------------------------------------
// Control fields and reset values
// ----------------------------------------
`define SCG_CTRL_MSEL_LSB 0
`define SCG_CTRL_SSEL     2
`define SCG_CTRL_OSC1_OFF 3
`define SCG_CTRL_OSC2_OFF 4
`define SCG_CTRL_RSEL     5
`define SCG_CTRL_HFMODE   6
`define SCG_CTRL_RST      8'h10
`define SCG_DCO_RST       8'h60
`define SCG_PINS_RST      3'h0
`define SCG_OSC_EN_RST    2'h1
`define SCG_ST_FAULT      0
`define SCG_ST_FAILSAFE   1

// ----------------------------------------
// Timing
// ----------------------------------------
`define SCG_CLK_PERIOD_NS 10
`define SCG_FAULT_TIME_NS 50000
`define SCG_FAULT_CYC ((`SCG_FAULT_TIME_NS + `SCG_CLK_PERIOD_NS - 1) / `SCG_CLK_PERIOD_NS)

`endif

/* pkg/scg_pkg.sv */
package scg_pkg;
  typedef enum logic [1:0] {SRC_DCO, SRC_LF, SRC_XT2} scg_src_t;
  typedef enum logic {MUX_RUN, MUX_PARK} scg_mux_st_t;
endpackage

/* pkg/scg_clk_if.sv */
`timescale 1ns/10ps
interface scg_clk_if;
  logic [2:0]        src;
  logic [2:0]        dead;
  scg_pkg::scg_src_t target;
  scg_pkg::scg_src_t cur;
  logic              clk_out;
  logic              busy;
  modport mux (input src, input dead, input target, output cur, output clk_out, output busy);
  modport ctl (output src, output dead, output target, input cur, input clk_out, input busy);
endinterface

/* core/scg_clk_mux.sv */
`timescale 1ns/10ps
module scg_clk_mux (
  input wire logic clk,
  input wire logic rst,
  scg_clk_if.mux   m
);
  scg_pkg::scg_mux_st_t state_reg;
  scg_pkg::scg_src_t    cur_reg;
  scg_pkg::scg_src_t    tgt_reg;
  logic                 seen_reg;
  logic                 out_reg;
  logic                 park_go;

  // ----------------------------------------
  // Park in a low phase, or at once when the current source is dead
  // ----------------------------------------
  // A dead source may be stuck high; cutting it is the lesser harm
  assign park_go = (m.target != cur_reg) && (!m.src[cur_reg] || m.dead[cur_reg]); // R12

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= scg_pkg::MUX_RUN;
      cur_reg   <= scg_pkg::SRC_DCO;
      tgt_reg   <= scg_pkg::SRC_DCO;
      seen_reg  <= 1'b0;
    end
    else
    begin
      case (state_reg)
        scg_pkg::MUX_RUN:
          if (park_go)
          begin
            state_reg <= scg_pkg::MUX_PARK;
            tgt_reg   <= m.target;
            seen_reg  <= 1'b0;
          end
        scg_pkg::MUX_PARK:
          // Join the new source only at a falling edge: whole low phase
          if (seen_reg && !m.src[tgt_reg]) // R12
          begin
            cur_reg   <= tgt_reg;
            state_reg <= scg_pkg::MUX_RUN;
          end
          else if (m.src[tgt_reg])
            seen_reg <= 1'b1;
        default: state_reg <= scg_pkg::MUX_RUN;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      out_reg <= 1'b0;
    else
      out_reg <= (state_reg == scg_pkg::MUX_RUN) && !park_go && m.src[cur_reg];
  end

  assign m.cur     = cur_reg;
  assign m.clk_out = out_reg;
  assign m.busy    = (state_reg == scg_pkg::MUX_PARK);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_park_holds_low: assert property (@(posedge clk) disable iff (rst) // R12
    (state_reg == scg_pkg::MUX_PARK) |-> !out_reg)
    else $error("clock output high while parked");
  a_fall_has_cause: assert property (@(posedge clk) disable iff (rst) // R12
    $fell(out_reg) |-> ($past(!m.src[cur_reg]) || $past(m.dead[cur_reg])
                        || $past(m.target != cur_reg)))
    else $error("clock output fell with no cause");
  a_switch_when_low: assert property (@(posedge clk) disable iff (rst) // R12
    $changed(cur_reg) |-> (!out_reg && $past(!m.src[tgt_reg]) && (cur_reg == $past(tgt_reg))))
    else $error("source changed outside a low phase");
endmodule

/* testbench/scg_xtal_model.sv */
`timescale 1ns/10ps
module scg_xtal_model #(
  parameter int INT_HALF = 2,
  parameter int LF_HALF  = 3,
  parameter int XT2_HALF = 4
) (
  input  wire logic clk,
  input  wire logic first_osc_enable,
  input  wire logic second_osc_enable,
  input  wire logic fail_first,
  input  wire logic fail_second,
  output logic      internal_osc_clock,
  output logic      low_freq_crystal_clock,
  output logic      second_crystal_clock
);
  int int_cnt;
  int lf_cnt;
  int xt2_cnt;

  initial
  begin
    int_cnt = 0;
    lf_cnt = 0;
    xt2_cnt = 0;
    internal_osc_clock = 1'b0;
    low_freq_crystal_clock = 1'b0;
    second_crystal_clock = 1'b0;
  end

  // Internal oscillator never stops
  always @(posedge clk)
  begin
    int_cnt <= (int_cnt == INT_HALF - 1) ? 0 : int_cnt + 1;
    if (int_cnt == INT_HALF - 1)
      internal_osc_clock <= ~internal_osc_clock;
  end

  // A failed or stopped crystal freezes at its level, as a real one does
  always @(posedge clk)
  begin
    if (first_osc_enable && !fail_first)
    begin
      lf_cnt <= (lf_cnt == LF_HALF - 1) ? 0 : lf_cnt + 1;
      if (lf_cnt == LF_HALF - 1)
        low_freq_crystal_clock <= ~low_freq_crystal_clock;
    end
  end

  always @(posedge clk)
  begin
    if (second_osc_enable && !fail_second)
    begin
      xt2_cnt <= (xt2_cnt == XT2_HALF - 1) ? 0 : xt2_cnt + 1;
      if (xt2_cnt == XT2_HALF - 1)
        second_crystal_clock <= ~second_crystal_clock;
    end
  end
endmodule

/* testbench/scg_top_tb.sv */
`timescale 1ns/10ps
`include "scg_cfg.svh"
module scg_top_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic        fail_first = 1'b0;
  logic        fail_second = 1'b0;
  logic [7:0]  rdata;
  logic [7:0]  dco_freq_code;
  logic        int_clk, lf_clk, xt2_clk, main_clock, subsystem_clock, aux_clock;
  logic        main_clock_pin, subsystem_clock_pin, aux_clock_pin;
  logic        first_osc_enable, second_osc_enable, first_osc_hf_mode;
  logic        osc_resistor_select, osc_fault_flag, nmi_req, irq;
  logic [15:0] rd_q[$];
  logic [31:0] seed = 32'h9997ee77;
  int          miscompares = 0;
  int          compares = 0;
  int          cycles = 0;

  always #5 clk = ~clk;

  scg_top #(.FAULT_CYCLES(20)) dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .internal_osc_clock(int_clk),
    .low_freq_crystal_clock(lf_clk), .second_crystal_clock(xt2_clk),
    .main_clock(main_clock), .subsystem_clock(subsystem_clock), .aux_clock(aux_clock),
    .main_clock_pin(main_clock_pin), .subsystem_clock_pin(subsystem_clock_pin),
    .aux_clock_pin(aux_clock_pin), .first_osc_enable(first_osc_enable),
    .second_osc_enable(second_osc_enable), .first_osc_hf_mode(first_osc_hf_mode),
    .osc_resistor_select(osc_resistor_select), .dco_freq_code(dco_freq_code),
    .osc_fault_flag(osc_fault_flag), .nmi_req(nmi_req), .irq(irq));

  scg_xtal_model xtal (.clk(clk), .first_osc_enable(first_osc_enable),
    .second_osc_enable(second_osc_enable), .fail_first(fail_first),
    .fail_second(fail_second), .internal_osc_clock(int_clk),
    .low_freq_crystal_clock(lf_clk), .second_crystal_clock(xt2_clk));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      stop_test();
    end
  end

  // ----------------------------------------
  // Output watchers
  // ----------------------------------------
  logic        rd_seen = 1'b0;
  logic        lf_prev = 1'b0;
  logic        mc_prev = 1'b0;
  logic        armed = 1'b0;
  int          run = 0;
  logic [15:0] note;

  always @(posedge clk)
  begin
    if (rd_seen && rd_q.size() > 0)
    begin
      note = rd_q.pop_front();
      check("rdata", rdata & note[15:8], note[7:0] & note[15:8]);
    end
    rd_seen = rd_en;
    if (!rst && cycles > 16)
    begin
      check("aux clock", {7'h0, aux_clock}, {7'h0, lf_prev});
      if (main_clock !== mc_prev)
      begin
        // Parking may stretch a phase, never shorten it below a source phase
        if (armed)
          check("main phase", {7'h0, run >= 2}, 8'h01);
        armed = 1'b1;
        run = 0;
      end
      run++;
    end
    lf_prev = lf_clk;
    mc_prev = main_clock;
  end

  // ----------------------------------------
  // Bus and helper tasks
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] mask);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    rd_q.push_back({mask, exp});
    @(posedge clk);
    rd_en <= 1'b0;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic sub_rate(input logic [7:0] ctrl, input int lo, input int hi);
    int   n;
    logic p;
    n = 0;
    wr(`SCG_OFS_CTRL, ctrl);
    cyc(60);
    p = subsystem_clock;
    repeat (48)
    begin
      @(posedge clk);
      if (subsystem_clock !== p)
        n++;
      p = subsystem_clock;
    end
    check("sub toggles", {7'h0, n >= lo && n <= hi}, 8'h01);
  endtask

  // Fail the crystal that feeds the main clock, then recover and clear
  task automatic fault_run(input logic [7:0] ctrl, input logic [1:0] sel);
    wr(`SCG_OFS_CTRL, ctrl);
    cyc(60);
    rd(`SCG_OFS_STATE, {6'h0, sel}, 8'h03);
    fail_first <= (sel == 2'h1);
    fail_second <= (sel == 2'h2);
    cyc(60);
    check("fault flag", {7'h0, osc_fault_flag}, 8'h01);
    check("nmi", {7'h0, nmi_req}, 8'h01);
    rd(`SCG_OFS_STAT, 8'h03, 8'h03);
    rd(`SCG_OFS_STATE, 8'h00, 8'h03);
    wr(`SCG_OFS_IEN, 8'h01);
    cyc(3);
    check("irq on", {7'h0, irq}, 8'h01);
    wr(`SCG_OFS_IEN, 8'h00);
    cyc(3);
    check("irq masked", {7'h0, irq}, 8'h00);
    fail_first <= 1'b0;
    fail_second <= 1'b0;
    cyc(40);
    check("flag sticky", {7'h0, osc_fault_flag}, 8'h01);
    rd(`SCG_OFS_STATE, 8'h00, 8'h03);
    wr(`SCG_OFS_CLR, 8'h03);
    cyc(3);
    check("flag cleared", {7'h0, osc_fault_flag}, 8'h00);
    check("nmi cleared", {7'h0, nmi_req}, 8'h00);
    rd(`SCG_OFS_STAT, 8'h00, 8'h03);
    wr(`SCG_OFS_CTRL, 8'h10);
    cyc(60);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  logic [2:0] c;

  initial
  begin
    cyc(12);
    rst <= 1'b0;
    cyc(2);
    check("first enable", {7'h0, first_osc_enable}, 8'h01);
    check("second enable", {7'h0, second_osc_enable}, 8'h00);
    check("resistor select", {7'h0, osc_resistor_select}, 8'h00);
    check("dco code", dco_freq_code, 8'h60);
    rd(`SCG_OFS_CTRL, 8'h10, 8'hff);
    rd(`SCG_OFS_DCO, 8'h60, 8'hff);
    rd(`SCG_OFS_STATE, 8'h04, 8'h0f);
    wr(`SCG_OFS_STAT, 8'hff);
    rd(`SCG_OFS_STAT, 8'h00, 8'hff);
    rd(`SCG_OFS_CLR, 8'h00, 8'hff);
    rd(4'hf, 8'h00, 8'hff);
    for (int i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      wr(`SCG_OFS_DCO, seed[7:0]);
      cyc(1);
      check("dco write", dco_freq_code, seed[7:0]);
      rd(`SCG_OFS_DCO, seed[7:0], 8'hff);
    end
    wr(`SCG_OFS_CTRL, 8'h70);
    cyc(2);
    check("hf mode", {7'h0, first_osc_hf_mode}, 8'h01);
    check("resistor set", {7'h0, osc_resistor_select}, 8'h01);
    rd(`SCG_OFS_CTRL, 8'h70, 8'hff);
    wr(`SCG_OFS_CTRL, 8'h01);
    cyc(60);
    rd(`SCG_OFS_STATE, 8'h01, 8'h03);
    wr(`SCG_OFS_CTRL, 8'h09);
    cyc(5);
    check("first kept", {7'h0, first_osc_enable}, 8'h01);
    wr(`SCG_OFS_CTRL, 8'h18);
    cyc(60);
    check("first stopped", {7'h0, first_osc_enable}, 8'h00);
    wr(`SCG_OFS_CTRL, 8'h02);
    cyc(60);
    rd(`SCG_OFS_STATE, 8'h02, 8'h03);
    wr(`SCG_OFS_CTRL, 8'h12);
    cyc(5);
    check("second kept", {7'h0, second_osc_enable}, 8'h01);
    wr(`SCG_OFS_CTRL, 8'h10);
    cyc(60);
    check("second stopped", {7'h0, second_osc_enable}, 8'h00);
    sub_rate(8'h04, 10, 14);
    sub_rate(8'h00, 22, 26);
    wr(`SCG_OFS_CTRL, 8'h10);
    for (int m = 0; m < 8; m++)
    begin
      wr(`SCG_OFS_PINS, 8'(m));
      cyc(3);
      repeat (6)
      begin
        @(posedge clk);
        c = {subsystem_clock, main_clock, aux_clock};
        @(posedge clk);
        check("pins", {5'h0, subsystem_clock_pin, main_clock_pin, aux_clock_pin},
              {5'h0, c & 3'(m)});
      end
    end
    fault_run(8'h01, 2'h1);
    fault_run(8'h02, 2'h2);
    cyc(3);
    stop_test();
  end
endmodule
